// >>> common/spsc_pkg.sv
// Package of offsets, field positions and reset values for the phase sequence control block
package spsc_pkg;
    // ==================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] SPSC_OFF_CTRL = 8'h00;
    localparam logic [7:0] SPSC_OFF_IST = 8'h04;
    localparam logic [7:0] SPSC_OFF_IMASK = 8'h08;
    localparam logic [7:0] SPSC_OFF_PHST = 8'h0c;
    // ==================================================
    // Control register fields
    localparam int SPSC_BIT_START = 0;
    localparam int SPSC_BIT_DONE = 1;
    localparam int SPSC_BIT_ERR = 2;
    localparam int SPSC_CNT_LSB = 4;
    localparam int SPSC_CNT_MSB = 6;
    localparam int SPSC_BIT_DMA = 8;
    // Interrupt status bits
    localparam int SPSC_IRQ_DONE = 0;
    localparam int SPSC_IRQ_ERR = 1;
    // ==================================================
    // Reset values
    localparam logic [2:0] SPSC_RST_CNT = 3'h0;
    localparam logic [1:0] SPSC_RST_IMASK = 2'h0;
    localparam int SPSC_NPHASE = 8;
    typedef enum logic [1:0] {
        SPSC_ST_IDLE,
        SPSC_ST_PHASE,
        SPSC_ST_DMA
    } spsc_state_t;
endpackage

// >>> logic/spsc_poll_judge.sv
// Poll attempt counter that judges one polling phase as passed or failed
module spsc_poll_judge
    import spsc_pkg::*;
#(
    parameter int LW = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic try_en,
    input wire logic hit,
    input wire logic [LW-1:0] limit,
    output logic ok,
    output logic fail
);
    logic [LW-1:0] count_ff;
    logic [LW-1:0] nxt_count;
    logic ok_ff;
    logic fail_ff;
    logic nxt_ok;
    logic nxt_fail;
    logic under;

    // ==================================================
    // Attempt counting
    always_comb begin
        under = (count_ff < limit);
        nxt_count = count_ff;
        nxt_ok = 1'b0;
        nxt_fail = 1'b0;
        if (clr) begin
            nxt_count = '0;
        end else if (try_en && !ok_ff && !fail_ff) begin
            // Match only counts while still under the limit
            if (hit && under) begin
                nxt_ok = 1'b1;
            end else if (!under || (count_ff + 1'b1 >= limit)) begin
                nxt_fail = 1'b1;
            end
            if (count_ff != {LW{1'b1}}) begin
                nxt_count = count_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
            ok_ff <= 1'b0;
            fail_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            ok_ff <= nxt_ok;
            fail_ff <= nxt_fail;
        end
    end

    assign ok = ok_ff;
    assign fail = fail_ff;

    // ==================================================
    // Checks
    poll_excl_a: assert property (@(posedge clk) disable iff (!rst_n) !(ok && fail))
        else $error("poll judged both passed and failed");
    poll_nomatch_a: assert property (@(posedge clk) disable iff (!rst_n)
        (try_en && !hit && !clr && !ok_ff && !fail_ff && count_ff + 1'b1 >= limit) |=> fail)
        else $error("poll limit reached without failure");
endmodule

// >>> logic/spsc_ctrl.sv
// Sequencer of phases with done, error and interrupt reporting for a serial flash controller
// ==================================================
// Summary of operation
// - Phase count field at bits 6-4 gives phases minus one, zero means one.
// - At communication end, error flag bit 2 sets if any executed phase failed.
// - Error and done flags clear on writing zero or on writing start one; here a start one written while busy is ignored and clears neither.
// - Done flag bit 1 sets only after serial and any DMA transfer end.
// - Phases run in ascending order from phase zero up to the count.
// - A poll phase fails when attempts reach the limit without a match.
//
// Decided for this implementation: the register addresses and strobed register access.
module spsc_ctrl
    import spsc_pkg::*;
#(
    parameter int NPH = SPSC_NPHASE,
    parameter int LW = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic phase_req,
    output logic [2:0] phase_idx,
    output logic phase_first,
    input wire logic phase_is_poll,
    input wire logic phase_end,
    input wire logic phase_err_in,
    input wire logic poll_try,
    input wire logic poll_hit,
    input wire logic [LW-1:0] poll_limit,
    output logic dma_req,
    input wire logic dma_done,
    output logic irq
);
    spsc_state_t state_ff;
    spsc_state_t nxt_state;
    logic [2:0] cnt_ff;
    logic [2:0] nxt_cnt;
    logic use_dma_ff;
    logic nxt_use_dma;
    logic [2:0] idx_ff;
    logic [2:0] nxt_idx;
    logic first_ff;
    logic nxt_first;
    logic dma_seen_ff;
    logic nxt_dma_seen;
    logic done_ff;
    logic nxt_done;
    logic err_ff;
    logic nxt_err;
    logic [NPH-1:0] ph_done_ff;
    logic [NPH-1:0] nxt_ph_done;
    logic [NPH-1:0] ph_err_ff;
    logic [NPH-1:0] nxt_ph_err;
    logic [1:0] ist_ff;
    logic [1:0] nxt_ist;
    logic [1:0] imask_ff;
    logic [1:0] nxt_imask;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic poll_ok;
    logic poll_fail;
    logic wr_ctrl;
    logic start;
    logic ph_end;
    logic ph_bad;
    logic last;
    logic finish;
    logic any_bad;

    // ==================================================
    // Poll judging
    spsc_poll_judge #(
        .LW(LW)
    ) u_poll (
        .clk(clk),
        .rst_n(rst_n),
        .clr(first_ff),
        .try_en(poll_try && phase_is_poll && state_ff == SPSC_ST_PHASE),
        .hit(poll_hit),
        .limit(poll_limit),
        .ok(poll_ok),
        .fail(poll_fail)
    );

    // ==================================================
    // Event decode
    always_comb begin
        wr_ctrl = reg_wr && (reg_addr == SPSC_OFF_CTRL);
        // Start while busy is ignored so a running sequence is never torn
        start = wr_ctrl && reg_wdata[SPSC_BIT_START] && (state_ff == SPSC_ST_IDLE);
        ph_end = (state_ff == SPSC_ST_PHASE) && !first_ff &&
            (phase_is_poll ? (poll_ok || poll_fail) : phase_end);
        ph_bad = phase_is_poll ? poll_fail : phase_err_in;
        last = (idx_ff == cnt_ff);
        any_bad = (|ph_err_ff) || (ph_end && ph_bad);
        finish = 1'b0;
        if (ph_end && last && (!use_dma_ff || dma_seen_ff || dma_done)) begin
            finish = 1'b1;
        end
        if ((state_ff == SPSC_ST_DMA) && dma_done) begin
            finish = 1'b1;
        end
    end

    // ==================================================
    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_first = 1'b0;
        nxt_dma_seen = dma_seen_ff || dma_done;
        nxt_ph_done = ph_done_ff;
        nxt_ph_err = ph_err_ff;
        case (state_ff)
            SPSC_ST_IDLE: begin
                if (start) begin
                    nxt_state = SPSC_ST_PHASE;
                    nxt_idx = 3'h0;
                    nxt_first = 1'b1;
                    nxt_dma_seen = 1'b0;
                    nxt_ph_done = '0;
                    nxt_ph_err = '0;
                end
            end
            SPSC_ST_PHASE: begin
                if (ph_end) begin
                    nxt_ph_done[idx_ff] = 1'b1;
                    if (ph_bad) begin
                        nxt_ph_err[idx_ff] = 1'b1;
                    end
                    if (!last) begin
                        nxt_idx = idx_ff + 3'h1;
                        nxt_first = 1'b1;
                    end else if (finish) begin
                        nxt_state = SPSC_ST_IDLE;
                    end else begin
                        nxt_state = SPSC_ST_DMA;
                    end
                end
            end
            SPSC_ST_DMA: begin
                if (finish) begin
                    nxt_state = SPSC_ST_IDLE;
                end
            end
            default: begin
                nxt_state = SPSC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SPSC_ST_IDLE;
            idx_ff <= 3'h0;
            first_ff <= 1'b0;
            dma_seen_ff <= 1'b0;
            ph_done_ff <= '0;
            ph_err_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            first_ff <= nxt_first;
            dma_seen_ff <= nxt_dma_seen;
            ph_done_ff <= nxt_ph_done;
            ph_err_ff <= nxt_ph_err;
        end
    end

    // ==================================================
    // Registers
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_use_dma = use_dma_ff;
        nxt_done = done_ff;
        nxt_err = err_ff;
        nxt_ist = ist_ff;
        nxt_imask = imask_ff;
        // Configuration is frozen while a sequence runs
        if (wr_ctrl && state_ff == SPSC_ST_IDLE) begin
            nxt_cnt = reg_wdata[SPSC_CNT_MSB:SPSC_CNT_LSB];
            nxt_use_dma = reg_wdata[SPSC_BIT_DMA];
        end
        // Writing one leaves a flag alone; only zero or start clears it
        if (wr_ctrl && (!reg_wdata[SPSC_BIT_DONE] || start)) begin
            nxt_done = 1'b0;
        end
        if (wr_ctrl && (!reg_wdata[SPSC_BIT_ERR] || start)) begin
            nxt_err = 1'b0;
        end
        if (reg_wr && reg_addr == SPSC_OFF_IST) begin
            nxt_ist = ist_ff & ~reg_wdata[1:0];
        end
        if (reg_wr && reg_addr == SPSC_OFF_IMASK) begin
            nxt_imask = reg_wdata[1:0];
        end
        // Hardware set wins over any clear in the same cycle
        if (finish) begin
            nxt_done = 1'b1;
            nxt_ist[SPSC_IRQ_DONE] = 1'b1;
            if (any_bad) begin
                nxt_err = 1'b1;
                nxt_ist[SPSC_IRQ_ERR] = 1'b1;
            end
        end
        nxt_rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                SPSC_OFF_CTRL: begin
                    nxt_rdata[SPSC_BIT_START] = (state_ff != SPSC_ST_IDLE);
                    nxt_rdata[SPSC_BIT_DONE] = done_ff;
                    nxt_rdata[SPSC_BIT_ERR] = err_ff;
                    nxt_rdata[SPSC_CNT_MSB:SPSC_CNT_LSB] = cnt_ff;
                    nxt_rdata[SPSC_BIT_DMA] = use_dma_ff;
                end
                SPSC_OFF_IST: begin
                    nxt_rdata[1:0] = ist_ff;
                end
                SPSC_OFF_IMASK: begin
                    nxt_rdata[1:0] = imask_ff;
                end
                SPSC_OFF_PHST: begin
                    nxt_rdata[15:0] = {8'(ph_err_ff), 8'(ph_done_ff)};
                end
                default: begin
                    nxt_rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= SPSC_RST_CNT;
            use_dma_ff <= 1'b0;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            ist_ff <= 2'h0;
            imask_ff <= SPSC_RST_IMASK;
            rdata_ff <= 32'h0;
        end else begin
            cnt_ff <= nxt_cnt;
            use_dma_ff <= nxt_use_dma;
            done_ff <= nxt_done;
            err_ff <= nxt_err;
            ist_ff <= nxt_ist;
            imask_ff <= nxt_imask;
            rdata_ff <= nxt_rdata;
        end
    end

    // ==================================================
    // Outputs
    assign reg_rdata = rdata_ff;
    assign phase_req = (state_ff == SPSC_ST_PHASE);
    assign phase_idx = idx_ff;
    assign phase_first = first_ff;
    // One-phase DMA is a software fault; the request is still gated to the last phase
    assign dma_req = use_dma_ff && (state_ff != SPSC_ST_IDLE) && last;
    assign irq = |(ist_ff & imask_ff);

    // ==================================================
    // Checks
    start_launch_a: assert property (@(posedge clk) disable iff (!rst_n)
        start |=> phase_req && idx_ff == 3'h0 && !done_ff && !err_ff && ph_err_ff == '0)
        else $error("start did not launch phase zero with cleared flags");
    idx_order_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ph_end && !last) |=> idx_ff == $past(idx_ff) + 3'h1 && phase_req)
        else $error("phase order not ascending");
    phase_count_a: assert property (@(posedge clk) disable iff (!rst_n)
        finish |=> $countones(ph_done_ff) == int'(cnt_ff) + 1 && ph_done_ff[0])
        else $error("phase count not honoured");
    err_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (finish && any_bad) |=> err_ff && done_ff)
        else $error("error flag missing after failed phase");
    done_dma_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(done_ff) |-> !$past(use_dma_ff) || $past(dma_seen_ff) || $past(dma_done))
        else $error("done set before dma ended");
    w0_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ctrl && !reg_wdata[SPSC_BIT_DONE] && !finish) |=> !done_ff)
        else $error("done not cleared by zero write");
    w1_noset_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!err_ff && !finish) |=> !err_ff)
        else $error("error flag set without hardware event");
    poll_err_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ph_end && phase_is_poll && poll_fail) |=> ph_err_ff[$past(idx_ff)])
        else $error("failed poll did not mark phase error");
    irq_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (finish && imask_ff[SPSC_IRQ_DONE] && !reg_wr) |=> irq ##1 (irq || $past(reg_wr)))
        else $error("interrupt not raised on completion");
    // Ones must keep both flags; catches a clear decoded with the wrong polarity
    flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_ctrl && reg_wdata[SPSC_BIT_DONE] && reg_wdata[SPSC_BIT_ERR] && !start && !finish)
        |=> done_ff == $past(done_ff) && err_ff == $past(err_ff))
        else $error("write of one changed a flag");
    idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == SPSC_ST_IDLE) |-> !phase_req && !phase_first && !dma_req)
        else $error("phase activity while idle");
endmodule

// >>> verification/spsc_flash_model.sv
// Behavioural far-side phase executor and DMA engine for the sequence bench
module spsc_flash_model
    import spsc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic phase_req,
    input wire logic [2:0] phase_idx,
    input wire logic phase_first,
    input wire logic dma_req,
    input wire logic [7:0] err_mask,
    input wire logic [7:0] poll_mask,
    input wire logic [7:0] hit_mask,
    input wire logic [7:0] dma_dly,
    output logic phase_is_poll,
    output logic phase_end,
    output logic phase_err_in,
    output logic poll_try,
    output logic poll_hit,
    output logic [7:0] poll_limit,
    output logic dma_done,
    output logic [3:0] seen,
    output logic order_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt;
    logic [7:0] dcnt;
    logic dfired;
    assign phase_is_poll = poll_mask[phase_idx];
    assign poll_limit = 8'h03;
    // Qualifiers invert outside their strobe so stale values never pass
    assign phase_err_in = phase_end ? err_mask[phase_idx] : ~err_mask[phase_idx];
    assign poll_hit = poll_try ? hit_mask[phase_idx] : ~hit_mask[phase_idx];
    // ==================================================
    // Phase execution
    // Four cycles per attempt keeps a stray try out of the next phase launch
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'h0;
            seen <= 4'h0;
            order_bad <= 1'b0;
            phase_end <= 1'b0;
            poll_try <= 1'b0;
        end else begin
            phase_end <= 1'b0;
            poll_try <= 1'b0;
            if (phase_first) begin
                cnt <= 3'h4;
                seen <= (phase_idx == 3'h0) ? 4'h1 : seen + 4'h1;
                if (phase_idx != 3'h0 && {1'b0, phase_idx} != seen) begin
                    order_bad <= 1'b1;
                end
            end else if (phase_req && cnt != 3'h0) begin
                cnt <= cnt - 3'h1;
                if (cnt == 3'h1) begin
                    if (phase_is_poll) begin
                        poll_try <= 1'b1;
                        cnt <= 3'h4;
                    end else begin
                        phase_end <= 1'b1;
                    end
                end
            end
        end
    end
    // ==================================================
    // DMA completion, once per request
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dcnt <= 8'h00;
            dfired <= 1'b0;
            dma_done <= 1'b0;
        end else begin
            dma_done <= 1'b0;
            if (!dma_req) begin
                dcnt <= 8'h00;
                dfired <= 1'b0;
            end else if (!dfired) begin
                dcnt <= dcnt + 8'h01;
                if (dcnt == dma_dly) begin
                    dma_done <= 1'b1;
                    dfired <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> verification/spsc_ctrl_tb.sv
// Self-checking testbench for the phase sequence control block
module spsc_ctrl_tb
    import spsc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, d;
    logic phase_req, phase_first, phase_is_poll, phase_end, phase_err_in;
    logic poll_try, poll_hit, dma_req, dma_done, irq, order_bad;
    logic [2:0] phase_idx;
    logic [7:0] poll_limit;
    logic [3:0] seen;
    logic [7:0] err_mask = 8'h00;
    logic [7:0] poll_mask = 8'h00;
    logic [7:0] hit_mask = 8'h00;
    logic [7:0] dma_dly = 8'h00;
    int fail_count = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    spsc_ctrl u_spsc_ctrl (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .phase_req(phase_req), .phase_idx(phase_idx), .phase_first(phase_first),
        .phase_is_poll(phase_is_poll), .phase_end(phase_end), .phase_err_in(phase_err_in),
        .poll_try(poll_try), .poll_hit(poll_hit), .poll_limit(poll_limit),
        .dma_req(dma_req), .dma_done(dma_done), .irq(irq));
    spsc_flash_model u_spsc_flash_model (.clk(clk), .rst_n(rst_n), .phase_req(phase_req),
        .phase_idx(phase_idx), .phase_first(phase_first), .dma_req(dma_req),
        .err_mask(err_mask), .poll_mask(poll_mask), .hit_mask(hit_mask), .dma_dly(dma_dly),
        .phase_is_poll(phase_is_poll), .phase_end(phase_end), .phase_err_in(phase_err_in),
        .poll_try(poll_try), .poll_hit(poll_hit), .poll_limit(poll_limit),
        .dma_done(dma_done), .seen(seen), .order_bad(order_bad));
    // ==================================================
    // Shared tasks
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic start(input logic [2:0] n, input logic dma);
        wr(SPSC_OFF_CTRL, {23'h0, dma, 1'b0, n, 4'h1});
    endtask
    // Polls busy; a run that never ends closes the bench
    task automatic finish(input logic [2:0] n, input logic [31:0] exp);
        int i;
        d = 32'h1;
        for (i = 0; i < 300 && d[SPSC_BIT_START] !== 1'b0; i++) rd(SPSC_OFF_CTRL, d);
        if (d[SPSC_BIT_START] !== 1'b0) begin
            fail_count++;
            results();
        end
        chk(d & 32'h6, exp);
        chk({28'h0, seen}, {29'h0, n} + 32'h1);
        chk({31'h0, order_bad}, 32'h0);
    endtask
    task automatic run(input logic [2:0] n, input logic dma, input logic [31:0] exp);
        start(n, dma);
        finish(n, exp);
    endtask
    // ==================================================
    // Scenarios
    task automatic t_counts();
        for (int n = 0; n < 8; n++) run(3'(n), 1'b0, 32'h2);
    endtask
    task automatic t_flags();
        err_mask = 8'h04;
        run(3'h2, 1'b0, 32'h6);
        wr(SPSC_OFF_CTRL, 32'h6);
        rd(SPSC_OFF_CTRL, d);
        chk(d & 32'h6, 32'h6);
        wr(SPSC_OFF_CTRL, 32'h0);
        rd(SPSC_OFF_CTRL, d);
        chk(d & 32'h6, 32'h0);
        err_mask = 8'h80;
        run(3'h7, 1'b0, 32'h6);
        err_mask = 8'h00;
        start(3'h3, 1'b0);
        rd(SPSC_OFF_CTRL, d);
        chk(d & 32'h6, 32'h0);
        finish(3'h3, 32'h2);
    endtask
    task automatic t_poll();
        poll_mask = 8'h02;
        hit_mask = 8'h02;
        run(3'h1, 1'b0, 32'h2);
        hit_mask = 8'h00;
        run(3'h1, 1'b0, 32'h6);
        rd(SPSC_OFF_PHST, d);
        chk(d & 32'hff00, 32'h0200);
        poll_mask = 8'h00;
    endtask
    task automatic t_dma();
        int i;
        dma_dly = 8'd40;
        start(3'h1, 1'b1);
        // Look after each edge so the launch of phase zero is seen first
        i = 0;
        do begin
            @(posedge clk);
            #1;
            i++;
        end while (i < 200 && phase_req !== 1'b0);
        if (phase_req !== 1'b0) begin
            fail_count++;
            results();
        end
        rd(SPSC_OFF_CTRL, d);
        chk(d & 32'h7, 32'h1);
        chk({31'h0, dma_req}, 32'h1);
        finish(3'h1, 32'h2);
        dma_dly = 8'd1;
        run(3'h2, 1'b1, 32'h2);
    endtask
    task automatic t_irq();
        // Earlier runs left both events pending
        wr(SPSC_OFF_IST, 32'h3);
        wr(SPSC_OFF_IMASK, 32'h1);
        run(3'h0, 1'b0, 32'h2);
        chk({31'h0, irq}, 32'h1);
        rd(SPSC_OFF_IST, d);
        chk(d, 32'h1);
        wr(SPSC_OFF_IST, 32'h1);
        wr(SPSC_OFF_IMASK, 32'h2);
        run(3'h0, 1'b0, 32'h2);
        chk({31'h0, irq}, 32'h0);
        err_mask = 8'h01;
        run(3'h0, 1'b0, 32'h6);
        chk({31'h0, irq}, 32'h1);
        wr(SPSC_OFF_IST, 32'h3);
        rd(SPSC_OFF_IST, d);
        chk(d, 32'h0);
        chk({31'h0, irq}, 32'h0);
        err_mask = 8'h00;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(SPSC_OFF_CTRL, d);
        chk(d, 32'h0);
        rd(SPSC_OFF_IMASK, d);
        chk(d, 32'h0);
        rd(8'h80, d);
        chk(d, 32'h0);
        t_counts();
        t_flags();
        t_poll();
        t_dma();
        t_irq();
        results();
    end
endmodule
